// ### fil_top.sv
`timescale 1ns/100ps
module fil_top (
  input  wire logic              clk_sys,      // system clock
  input  wire logic              resetn,       // async reset, low
  input  wire logic              clkEn,        // freezes state when low
  input  wire fil_pkg::fil_cond_t cond,        // live fault conditions
  input  wire fil_pkg::fil_avreq_t avReq,      // avalon request
  output logic [31:0]            readdata,     // avalon read data
  output logic                   waitrequest,  // avalon wait
  output logic                   irq_out_n,    // fault interrupt, low active
  output logic                   irq,          // sticky event interrupt
  output logic                   mirror_regulator_enable, // regulator enable
  output logic                   switchMap,    // led switch map select
  output logic                   serialEnable, // serial port enabled
  output fil_pkg::fil_pwr_t      powerState    // power mode
);
  import fil_pkg::*;

  // ==========================================================
  // bus decode
  // ==========================================================
  logic [7:0]  regIdx;      // register index
  logic        aligned;     // word aligned access
  logic        ack;         // access completes this cycle
  logic        wrLow;       // write with low lane enabled
  logic [7:0]  wData;       // low byte of write data
  logic [7:0]  status;      // live fault status
  logic [7:0]  mask;        // fault mask
  logic [7:0]  syscfg;      // system config
  logic [7:0]  irqEn;       // sticky interrupt enable
  logic [7:0]  irqStat;     // sticky event bits
  logic [7:0]  condPrev;    // previous status for edge
  logic        unlocked;    // protected writes allowed
  logic        keyArmed;    // first key byte seen
  logic [19:0] uvloCnt;     // undervoltage_lockout_flag delay counter
  logic        uvloDone;    // delay expired

  // register index from byte address
  function automatic logic [7:0] idxOf(input logic [9:0] a);
    idxOf = a[9:2];
  endfunction : idxOf

  assign regIdx  = idxOf(avReq.address);
  assign aligned = (avReq.address[1:0] == 2'b00);
  assign wData   = avReq.writedata[7:0];
  assign wrLow   = ack && avReq.write && avReq.byteenable[0] && aligned;
  // status is the live condition vector, writes never touch it
  assign status  = cond;

  // ==========================================================
  // avalon handshake: one wait cycle, answer on second edge
  // ==========================================================
  // waitrequest high at request start, low for the finishing cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      if ((avReq.read || avReq.write) && waitrequest) begin
        waitrequest <= 1'b0;  // answer next cycle
      end else begin
        waitrequest <= 1'b1;  // idle or just finished
      end
    end
  end
  assign ack = clkEn && !waitrequest && (avReq.read || avReq.write);

  // read data prepared while waiting
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h00000000;
    end else if (clkEn && avReq.read && waitrequest) begin
      if (!aligned) begin
        readdata <= RD_UNMAPPED;
      end else begin
        case (regIdx)
          IDX_STATUS:  readdata <= {24'h000000, status};
          IDX_MASK:    readdata <= {24'h000000, mask};
          IDX_KEY:     readdata <= {24'h000000, unlocked ? KEY_RD_OPEN : KEY_RD_LOCK};
          IDX_SYSCFG:  readdata <= {24'h000000, syscfg};
          IDX_IRQEN:   readdata <= {24'h000000, irqEn};
          IDX_IRQSTAT: readdata <= {24'h000000, irqStat};
          IDX_POWER:   readdata <= {23'h000000, mirror_regulator_enable, 4'h0, powerState};
          default:     readdata <= RD_UNMAPPED;
        endcase
      end
    end
  end

  // ==========================================================
  // unlock sequence
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      unlocked <= 1'b0;
      keyArmed <= 1'b0;
    end else if (clkEn && wrLow) begin
      if (regIdx == IDX_KEY) begin
        if (keyArmed && wData == KEY_SECOND) begin
          unlocked <= 1'b1;
          keyArmed <= 1'b0;
        end else if (wData == KEY_FIRST) begin
          keyArmed <= 1'b1;
        end else begin
          keyArmed <= 1'b0;
          if (wData == KEY_LOCK) begin
            unlocked <= 1'b0;
          end
        end
      end else begin
        keyArmed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // protected registers: mask and syscfg
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask   <= RST_BYTE;
      syscfg <= RST_BYTE;
    end else if (clkEn && wrLow && unlocked) begin
      if (regIdx == IDX_MASK) begin
        mask <= wData;
      end
      if (regIdx == IDX_SYSCFG) begin
        syscfg <= wData & SYSCFG_WMASK;
      end
    end
  end

  // ==========================================================
  // sticky event interrupt
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqEn    <= RST_BYTE;
      irqStat  <= RST_BYTE;
      condPrev <= RST_BYTE;
    end else if (clkEn) begin
      condPrev <= status;
      if (wrLow && regIdx == IDX_IRQEN) begin
        irqEn <= wData;
      end
      // rising condition sets; set wins over clear
      if (wrLow && regIdx == IDX_IRQCLR) begin
        irqStat <= (irqStat & ~wData) | (status & ~condPrev);
      end else begin
        irqStat <= irqStat | (status & ~condPrev);
      end
    end
  end

  // ==========================================================
  // power state and regulator enable
  // ==========================================================
  assign uvloDone = (uvloCnt == 20'(UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES - 1));

  // undervoltage_lockout_flag delay counter, runs while undervoltage_lockout_flag holds
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      uvloCnt <= 20'h00000;
    end else if (clkEn) begin
      if (!status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG]) begin
        uvloCnt <= 20'h00000;
      end else if (!uvloDone) begin
        uvloCnt <= uvloCnt + 20'h00001;
      end
    end
  end

  // power mode machine; reset state exits only by device reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      powerState              <= PWR_ACTIVE;
      mirror_regulator_enable <= RST_REGEN;
      serialEnable            <= 1'b1;
    end else if (clkEn) begin
      if (status[BIT_MIRR] || status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG]) begin
        mirror_regulator_enable <= 1'b0;
      end else if (wrLow && unlocked && regIdx == IDX_POWER) begin
        mirror_regulator_enable <= wData[0];
      end
      case (powerState)
        PWR_RESET: begin
          serialEnable <= 1'b0;
        end
        default: begin
          if (status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] && uvloDone) begin
            powerState   <= PWR_RESET;
            serialEnable <= 1'b0;
          end else if (status[BIT_PROJ]) begin
            powerState <= PWR_OFF;
          end else if (status[BIT_MIRR] || status[BIT_TSD]) begin
            powerState <= PWR_STANDBY;
          end else if (powerState != PWR_STANDBY) begin
            powerState <= PWR_ACTIVE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // output pins
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_out_n <= 1'b1;
      irq       <= 1'b0;
      switchMap <= 1'b0;
    end else if (clkEn) begin
      irq_out_n <= ~|(status & ~mask);
      irq       <= |(irqStat & irqEn);
      switchMap <= syscfg[BIT_MAP];
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  irq_follows_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn |=> irq_out_n == ~|($past(status) & ~$past(mask)))
    else $error("irq pin mismatch");
  key_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ack && avReq.read && regIdx == IDX_KEY && aligned) |-> readdata[7:0] == {7'h00, unlocked})
    else $error("key readback wrong");
  locked_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!unlocked && clkEn) |=> $stable(mask) && $stable(syscfg))
    else $error("locked write took effect");
  unlock_seq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrLow && regIdx == IDX_KEY && wData == KEY_SECOND && keyArmed) |=> unlocked)
    else $error("unlock failed");
  relock_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrLow && regIdx == IDX_KEY && wData == KEY_LOCK) |=> !unlocked)
    else $error("relock failed");
  abandon_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (wrLow && regIdx != IDX_KEY) |=> !keyArmed)
    else $error("sequence not abandoned");
  regen_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clkEn && (status[BIT_MIRR] || status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG])) |=> !mirror_regulator_enable)
    else $error("regulator enable kept");
  proj_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clkEn && status[BIT_PROJ] && !status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] && powerState != PWR_RESET) |=> powerState == PWR_OFF)
    else $error("not off");
  tsd_stby_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clkEn && status[BIT_TSD] && !status[BIT_PROJ] && !status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] && powerState != PWR_RESET)
    |=> powerState == PWR_STANDBY)
    else $error("not standby");
  undervoltage_lockout_flag_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clkEn && status[BIT_UNDERVOLTAGE_LOCKOUT_FLAG] && uvloDone) |=> powerState == PWR_RESET && !serialEnable)
    else $error("no reset after undervoltage_lockout_flag");
  status_rd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clkEn && avReq.read && waitrequest && aligned && regIdx == IDX_STATUS) |=> readdata[7:0] == $past(cond))
    else $error("status read wrong");
  cfg_map_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    clkEn |=> switchMap == $past(syscfg[BIT_MAP]))
    else $error("map not applied");
  unlock_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(unlocked));
  irq_c: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(irq_out_n));
  reset_c: cover property (@(posedge clk_sys) disable iff (!resetn) powerState == PWR_RESET);
endmodule : fil_top

// ### fil_pkg.sv
package fil_pkg;
  // ==========================================================
  // register map (printed offsets are not all multiples of 4,
  // so the printed offset is a register index; byte = 4*index)
  // ==========================================================
  localparam logic [7:0] IDX_STATUS   = 8'h0C;  // fault_status
  localparam logic [7:0] IDX_MASK     = 8'h0D;  // fault_interrupt_mask
  localparam logic [7:0] IDX_KEY      = 8'h10;  // write_unlock_key
  localparam logic [7:0] IDX_SYSCFG   = 8'h11;  // system_config
  localparam logic [7:0] IDX_IRQEN    = 8'h12;  // irq enable
  localparam logic [7:0] IDX_IRQSTAT  = 8'h13;  // sticky event status
  localparam logic [7:0] IDX_IRQCLR   = 8'h14;  // sticky clear, write-only
  localparam logic [7:0] IDX_POWER    = 8'h15;  // power state / regulator enable
  // ==========================================================
  // field positions and values
  // ==========================================================
  localparam int         BIT_OVP      = 7;      // led supply overvoltage
  localparam int         BIT_SIXV     = 6;      // six volt rail fault
  localparam int         BIT_PROJ     = 5;      // projector enable low
  localparam int         BIT_MIRR     = 4;      // mirror regulator fault
  localparam int         BIT_UNDERVOLTAGE_LOCKOUT_FLAG     = 3;      // undervoltage lockout
  localparam int         BIT_LOWBAT   = 2;      // low battery
  localparam int         BIT_TSD      = 1;      // thermal shutdown
  localparam int         BIT_HOT      = 0;      // thermal warning
  localparam int         BIT_MAP      = 0;      // switch map select
  localparam int         BIT_RSVD1    = 1;      // reserved, write as 0
  localparam logic [7:0] SYSCFG_WMASK = 8'h03;  // writable syscfg bits
  localparam logic [7:0] KEY_FIRST    = 8'hBA;  // unlock byte one
  localparam logic [7:0] KEY_SECOND   = 8'hBE;  // unlock byte two
  localparam logic [7:0] KEY_LOCK     = 8'h00;  // relock value
  localparam logic [7:0] KEY_RD_LOCK  = 8'h00;  // read while locked
  localparam logic [7:0] KEY_RD_OPEN  = 8'h01;  // read while unlocked
  localparam logic [7:0] RST_BYTE     = 8'h00;  // reset of rw registers
  localparam logic       RST_REGEN    = 1'b1;   // regulator enable after reset
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000; // unmapped read answer
  // ==========================================================
  // timing
  // ==========================================================
  localparam int         CLK_HZ       = 25000000;  // system clock
  localparam int         UNDERVOLTAGE_LOCKOUT_FLAG_MS      = 25;        // undervoltage_lockout_flag to reset delay
  localparam int         UNDERVOLTAGE_LOCKOUT_FLAG_CYCLES  = (CLK_HZ / 1000) * UNDERVOLTAGE_LOCKOUT_FLAG_MS;
  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [3:0] {
    PWR_ACTIVE  = 4'b0001,
    PWR_STANDBY = 4'b0010,
    PWR_OFF     = 4'b0100,
    PWR_RESET   = 4'b1000
  } fil_pwr_t;
  // live analog condition inputs
  typedef struct packed {
    logic ovp;      // led supply above ovp threshold
    logic sixv;     // six volt rail out of regulation
    logic projLow;  // projector enable pin low
    logic mirror;   // mirror regulator fault
    logic undervoltage_lockout_flag;     // battery below undervoltage_lockout_flag
    logic lowBat;   // battery below low threshold
    logic thermal_shutdown_flag;      // thermal shutdown active
    logic hot;      // above hot threshold
  } fil_cond_t;
  // avalon request
  typedef struct packed {
    logic [9:0]  address;    // byte address
    logic        read;       // read strobe
    logic        write;      // write strobe
    logic [3:0]  byteenable; // lanes
    logic [31:0] writedata;  // write data
  } fil_avreq_t;
endpackage : fil_pkg

// ### fil_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// host model: avalon master with the unlock habits of the host
// ==========================================================
module fil_host_model (
  input  wire logic                 clk_sys,     // system clock
  input  wire logic                 waitrequest, // slave stall
  input  wire logic [31:0]          readdata,    // read answer
  output fil_pkg::fil_avreq_t       avReq        // request bundle
);
  import fil_pkg::*;
  // idle bus at time zero
  initial avReq = '0;
  // one transfer, held until waitrequest is sampled low
  task automatic xfer(input logic isWr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk_sys);
    avReq.address    <= {idx, 2'b00};
    avReq.read       <= ~isWr;
    avReq.write      <= isWr;
    avReq.byteenable <= 4'hF;
    avReq.writedata  <= {24'h000000, wd};
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    avReq.read      <= 1'b0;
    avReq.write     <= 1'b0;
    avReq.writedata <= ~{24'h000000, wd};  // released data no longer valid
  endtask : xfer
  // plain register write
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] dummy;
    xfer(1'b1, idx, wd, dummy);
  endtask : wr
  // plain register read
  task automatic rd(input logic [7:0] idx, output logic [7:0] val);
    xfer(1'b0, idx, 8'h00, val);
  endtask : rd
  // two key bytes, nothing written between them
  task automatic unlock;
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_KEY, KEY_SECOND);
  endtask : unlock
  // switch map write, reserved bit kept at zero
  task automatic syscfg(input logic map);
    wr(IDX_SYSCFG, {7'h00, map});
  endtask : syscfg
endmodule : fil_host_model

// ### fil_top_tb.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the fault interrupt block
// ==========================================================
module fil_top_tb;
  import fil_pkg::*;
  localparam int LIMIT = 20000;   // cycle ceiling for the run
  logic        clk_sys;           // system clock
  logic        resetn;            // async reset, low
  logic        clkEn;             // clock enable, tied high
  fil_cond_t   cond;              // live conditions
  fil_avreq_t  avReq;             // bus request from host
  logic [31:0] readdata;          // bus read data
  logic        waitrequest;       // bus stall
  logic        irq_out_n;         // fault interrupt, low active
  logic        irq;               // sticky event interrupt
  logic        regEn;             // regulator enable
  logic        switchMap;         // switch map select
  logic        serialEnable;      // serial port enable
  fil_pwr_t    powerState;        // power mode
  int          n_errors;          // mismatches
  int          cmp_count;         // comparisons
  int          cycles;            // watchdog count
  logic [7:0]  rv;                // last read value
  int          bits[4] = '{7, 6, 2, 0};
  fil_top uut (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn), .cond(cond), .avReq(avReq),
    .readdata(readdata), .waitrequest(waitrequest), .irq_out_n(irq_out_n), .irq(irq),
    .mirror_regulator_enable(regEn), .switchMap(switchMap), .serialEnable(serialEnable),
    .powerState(powerState));
  fil_host_model host (.clk_sys(clk_sys), .waitrequest(waitrequest), .readdata(readdata), .avReq(avReq));
  // clock generation
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  // watchdog against hangs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_errors++;
      test_done();
    end
  end
  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // one comparison
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // register read and compare
  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    host.rd(idx, rv);
    chk(what, {24'h000000, exp}, {24'h000000, rv});
  endtask : rdchk
  // wait whole cycles
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold
  // drive conditions and let them settle
  task automatic setc(input logic [7:0] v);
    @(posedge clk_sys);
    cond <= v;
    hold(3);
  endtask : setc
  // reset held for 20 cycles
  task automatic do_reset;
    @(posedge clk_sys);
    cond   <= '0;
    resetn <= 1'b0;
    hold(20);
    resetn <= 1'b1;
  endtask : do_reset
  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    resetn = 1'b0;
    clkEn = 1'b1;
    cond = '0;
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    do_reset();
    rdchk("mask", IDX_MASK, RST_BYTE);
    rdchk("key", IDX_KEY, KEY_RD_LOCK);
    rdchk("syscfg", IDX_SYSCFG, RST_BYTE);
    rdchk("unmapped", 8'h30, 8'h00);
    chk("irq_out_n", 1, irq_out_n);
    $display("test reset done");
    // flags that leave operation running
    for (int i = 0; i < 4; i++) begin
      setc(8'h01 << bits[i]);
      rdchk("status", IDX_STATUS, 8'h01 << bits[i]);
      chk("irq_out_n", 0, irq_out_n);
      chk("power", PWR_ACTIVE, powerState);
    end
    setc(8'h00);
    chk("irq_out_n", 1, irq_out_n);
    setc(8'h85);
    host.wr(IDX_STATUS, 8'h7A);
    rdchk("status", IDX_STATUS, 8'h85);
    $display("test status done");
    // lock, unlock, mask
    host.wr(IDX_MASK, 8'hFF);
    rdchk("mask", IDX_MASK, 8'h00);
    host.unlock();
    rdchk("key", IDX_KEY, KEY_RD_OPEN);
    host.wr(IDX_MASK, 8'h85);
    rdchk("mask", IDX_MASK, 8'h85);
    hold(3);
    chk("irq_out_n", 1, irq_out_n);
    setc(8'hC5);
    chk("irq_out_n", 0, irq_out_n);
    host.wr(IDX_KEY, KEY_LOCK);
    rdchk("key", IDX_KEY, KEY_RD_LOCK);
    host.wr(IDX_MASK, 8'h00);
    rdchk("mask", IDX_MASK, 8'h85);
    setc(8'h00);
    $display("test lock done");
    // broken sequence, then reads between key bytes
    host.wr(IDX_KEY, KEY_FIRST);
    host.wr(IDX_SYSCFG, 8'h01);
    host.wr(IDX_KEY, KEY_SECOND);
    rdchk("key", IDX_KEY, KEY_RD_LOCK);
    rdchk("syscfg", IDX_SYSCFG, 8'h00);
    host.wr(IDX_KEY, KEY_FIRST);
    host.rd(IDX_STATUS, rv);
    host.wr(IDX_KEY, KEY_SECOND);
    rdchk("key", IDX_KEY, KEY_RD_OPEN);
    host.syscfg(1'b1);
    rdchk("syscfg", IDX_SYSCFG, 8'h01);
    chk("switchMap", 1, switchMap);
    host.syscfg(1'b0);
    hold(2);
    chk("switchMap", 0, switchMap);
    $display("test unlock done");
    // sticky event interrupt: raise, clear, disable
    host.wr(IDX_IRQCLR, 8'hFF);  // drop edges caught by earlier tests
    host.wr(IDX_IRQEN, 8'h04);
    setc(8'h04);
    chk("irq", 1, irq);
    rdchk("sticky", IDX_IRQSTAT, 8'h04);
    setc(8'h00);
    host.wr(IDX_IRQCLR, 8'h04);
    hold(2);
    chk("irq", 0, irq);
    host.wr(IDX_IRQEN, 8'h00);
    setc(8'h04);
    chk("irq", 0, irq);
    $display("test irq done");
    // power effects of the shutting flags
    do_reset();
    setc(8'h20);
    chk("power", PWR_OFF, powerState);
    setc(8'h00);
    chk("power", PWR_ACTIVE, powerState);
    do_reset();
    setc(8'h10);
    chk("power", PWR_STANDBY, powerState);
    chk("regen", 0, regEn);
    do_reset();
    setc(8'h02);
    chk("power", PWR_STANDBY, powerState);
    chk("regen", 1, regEn);
    host.wr(IDX_POWER, 8'h00);
    hold(1);
    chk("regen", 1, regEn);
    rdchk("power reg", IDX_POWER, 8'h02);
    host.unlock();
    host.wr(IDX_POWER, 8'h00);
    hold(1);
    chk("regen", 0, regEn);
    do_reset();
    setc(8'h08);
    chk("regen", 0, regEn);
    chk("serial", 1, serialEnable);
    rdchk("status", IDX_STATUS, 8'h08);
    $display("test power done");
    test_done();
  end
endmodule : fil_top_tb
